/* File: hdl/pgl_cfg.svh */
// Purpose: Constants of the PHY general-purpose and low-power register bank
// Assumes: Clause 22 management frames, one clock clk_sys at 250 MHz
// Notes:   Definitions only; included by bare name
`ifndef PGL_CFG_SVH
`define PGL_CFG_SVH

// ****************************************
// Management frame
// ****************************************
`define PGL_PREAMBLE_MIN   6'h20
`define PGL_OP_READ        2'h2
`define PGL_OP_WRITE       2'h1
`define PGL_HDR_LAST       4'hC
`define PGL_DATA_LAST      4'hF

// ****************************************
// Addresses and pages
// ****************************************
`define PGL_REG_PAGE       5'h1F
`define PGL_PAGE_GP        16'h0010
`define PGL_PAGE_STD       16'h0000
`define PGL_REG_MMD_CTRL   5'h0D
`define PGL_REG_MMD_DATA   5'h0E
`define PGL_GP_SLEEP       5'h0E
`define PGL_GP_IRQ         5'h1D
`define PGL_MMD_DEV_PCS    5'h03
`define PGL_MMD_DEV_AN     5'h07
`define PGL_MMD_A_STATUS   16'h0001
`define PGL_MMD_A_CAPS     16'h0014
`define PGL_MMD_A_WAKE     16'h0016
`define PGL_MMD_A_ADV      16'h003C
`define PGL_MMD_A_LPADV    16'h003D

// Register indices within the low-power group
`define PGL_IDX_STATUS     3'h0
`define PGL_IDX_CAPS       3'h1
`define PGL_IDX_WAKE       3'h2
`define PGL_IDX_ADV        3'h3
`define PGL_IDX_LPADV      3'h4
`define PGL_IDX_NONE       3'h7

// ****************************************
// Field positions and reset values
// ****************************************
`define PGL_SLEEP_DIR_N    13
`define PGL_SLEEP_OUT      12
`define PGL_SLEEP_IN       11
`define PGL_IRQ_THERMAL    12
`define PGL_ST_TX_SEEN     11
`define PGL_ST_RX_SEEN     10
`define PGL_ST_TX_NOW      9
`define PGL_ST_RX_NOW      8
`define PGL_ST_LINK        2
`define PGL_GIG_BIT        2
`define PGL_FAST_BIT       1
`define PGL_CAPS_VALUE     16'h0006
`define PGL_PORTS          12
`define PGL_WAKE_RESET     16'h0000
`define PGL_PHY_ADDR       5'h00

`endif

/* File: hdl/pgl_pkg.sv */
// Purpose: Types shared by the register bank files
// Assumes: Constants live in pgl_cfg.svh
// Notes:   No imports; users write pgl_pkg::name
package pgl_pkg;

	// Management frame phases
	typedef enum logic [1:0] {
		FR_IDLE,
		FR_HDR,
		FR_TA,
		FR_DATA
	} pgl_frame_e;

	// One management register word
	typedef logic [15:0] pgl_word_t;

endpackage

/* File: hdl/pgl_pin_sync.sv */
// Purpose: Three-stage synchroniser for a pin from outside the clock domain
// Assumes: Output changes only once stages two and three agree
// Notes:   Stage one feeds stage two only
`timescale 1ns/1ps
module pgl_pin_sync #(
	parameter logic INIT = 1'b1
) (
	input  wire logic clk_sys,
	input  wire logic rstSync_n,
	input  wire logic pinIn,
	output logic      pinOut
);

	logic stage1Reg;
	logic stage2Reg;
	logic stage3Reg;

	// ****************************************
	// Capture chain
	// ****************************************
	// Shift the pin through three stages
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			stage1Reg <= INIT;
			stage2Reg <= INIT;
			stage3Reg <= INIT;
		end else begin
			stage1Reg <= pinIn;
			stage2Reg <= stage1Reg;
			stage3Reg <= stage2Reg;
		end
	end

	// Accept a level only when two stages agree, filters one-cycle glitches
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			pinOut <= INIT;
		end else if (stage2Reg == stage3Reg) begin
			pinOut <= stage3Reg;
		end
	end

endmodule

/* File: hdl/pgl_wake_cnt.sv */
// Purpose: Wake-fault event counter, cleared on read
// Assumes: Event and clear strobes are one-cycle pulses on clk_sys
// Notes:   Saturates at all ones rather than wrapping
`timescale 1ns/1ps
`include "pgl_cfg.svh"
module pgl_wake_cnt (
	input  wire logic        clk_sys,
	input  wire logic        rstSync_n,
	input  wire logic        softReset,
	input  wire logic        faultRefresh,
	input  wire logic        faultWakeup,
	input  wire logic        readClear,
	output pgl_pkg::pgl_word_t count
);

	logic [1:0]  incAmount;
	logic [16:0] sum;

	// ****************************************
	// Counter
	// ****************************************
	// Both fault sources count, even in the same cycle
	assign incAmount = {1'b0, faultRefresh} + {1'b0, faultWakeup};
	assign sum       = {1'b0, count} + {15'h0000, incAmount};

	// An event in the clearing cycle survives the clear
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			count <= `PGL_WAKE_RESET;
		end else if (softReset) begin
			count <= `PGL_WAKE_RESET;
		end else if (readClear) begin
			count <= {14'h0000, incAmount};
		end else if (sum[16]) begin
			count <= 16'hFFFF;
		end else begin
			count <= sum[15:0];
		end
	end

endmodule

/* File: hdl/pgl_regs.sv */
// Purpose: Management slave with general-purpose page and low-power registers
// Assumes: mdc and mdio arrive from pins; status inputs are on clk_sys
// Notes:   mdc is oversampled, so it must stay well below clk_sys / 8
`timescale 1ns/1ps
`include "pgl_cfg.svh"
module pgl_regs #(
	parameter logic [4:0] PHY_ADDR = `PGL_PHY_ADDR
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        softReset,
	input  wire logic        mdc,
	input  wire logic        mdioI,
	output logic             mdioO,
	output logic             mdioOe,
	input  wire logic        sleepPinI,
	output logic             sleepPinO,
	output logic             sleepPinOe,
	input  wire logic        thermalIrqEvent,
	input  wire logic [11:0] portIrqEvent,
	input  wire logic [11:0] portStatusRead,
	input  wire logic        txIdleNow,
	input  wire logic        rxIdleNow,
	input  wire logic        rxLinkUp,
	input  wire logic        wakeFaultRefresh,
	input  wire logic        wakeFaultWakeup,
	input  wire logic        anComplete,
	input  wire logic        partnerGigAdvert,
	input  wire logic        partnerFastAdvert,
	output logic             gigAdvertOut,
	output logic             fastAdvertOut,
	output logic             irqOut
);

	// ****************************************
	// Reset release and pin capture
	// ****************************************
	logic rstMeta;
	logic rstSync_n;

	// Release reset through two stages so all flops leave reset together
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta   <= 1'b0;
			rstSync_n <= 1'b0;
		end else begin
			rstMeta   <= 1'b1;
			rstSync_n <= rstMeta;
		end
	end

	logic mdcS;
	logic mdioS;
	logic sleepS;
	logic mdcPrev;
	logic mdcRise;

	pgl_pin_sync #(.INIT(1'b1)) uMdcSync (
		.clk_sys   (clk_sys),
		.rstSync_n (rstSync_n),
		.pinIn     (mdc),
		.pinOut    (mdcS)
	);

	pgl_pin_sync #(.INIT(1'b1)) uMdioSync (
		.clk_sys   (clk_sys),
		.rstSync_n (rstSync_n),
		.pinIn     (mdioI),
		.pinOut    (mdioS)
	);

	pgl_pin_sync #(.INIT(1'b0)) uSleepSync (
		.clk_sys   (clk_sys),
		.rstSync_n (rstSync_n),
		.pinIn     (sleepPinI),
		.pinOut    (sleepS)
	);

	// Rising edge of the filtered management clock
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			mdcPrev <= 1'b1;
		end else begin
			mdcPrev <= mdcS;
		end
	end

	assign mdcRise = mdcS & ~mdcPrev;

	// ****************************************
	// Frame engine
	// ****************************************
	pgl_pkg::pgl_frame_e frameReg;
	logic [5:0]          onesCnt;
	logic [3:0]          bitCnt;
	logic [11:0]         hdrShift;
	logic [12:0]         hdrFull;
	logic                isRead;
	logic                isWrite;
	logic [4:0]          regAddr;
	pgl_pkg::pgl_word_t  rdShift;
	pgl_pkg::pgl_word_t  wrShift;
	pgl_pkg::pgl_word_t  rdValue;
	logic                rdStrobe;
	logic                wrStrobe;
	pgl_pkg::pgl_word_t  wrData;
	logic                hdrDone;

	assign hdrFull = {hdrShift, mdioS};
	assign hdrDone = mdcRise && (frameReg == pgl_pkg::FR_HDR) && (bitCnt == `PGL_HDR_LAST);
	assign wrData  = {wrShift[14:0], mdioS};

	// Phase sequencing: preamble, header, turnaround, data
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			frameReg <= pgl_pkg::FR_IDLE;
			onesCnt  <= 6'h00;
			bitCnt   <= 4'h0;
		end else if (mdcRise) begin
			unique case (frameReg)
				pgl_pkg::FR_IDLE: begin
					bitCnt <= 4'h0;
					if (mdioS) begin
						onesCnt <= (onesCnt == 6'h3F) ? onesCnt : onesCnt + 6'h01;
					end else begin
						onesCnt <= 6'h00;
						if (onesCnt >= `PGL_PREAMBLE_MIN) begin
							frameReg <= pgl_pkg::FR_HDR;
						end
					end
				end
				pgl_pkg::FR_HDR: begin
					bitCnt <= bitCnt + 4'h1;
					if (bitCnt == `PGL_HDR_LAST) begin // Thirteen bits after the first start bit
						bitCnt   <= 4'h0;
						frameReg <= pgl_pkg::FR_TA;
					end
				end
				pgl_pkg::FR_TA: begin
					bitCnt <= bitCnt + 4'h1;
					if (bitCnt == 4'h1) begin
						bitCnt   <= 4'h0;
						frameReg <= pgl_pkg::FR_DATA;
					end
				end
				pgl_pkg::FR_DATA: begin
					bitCnt <= bitCnt + 4'h1;
					if (bitCnt == `PGL_DATA_LAST) begin
						bitCnt   <= 4'h0;
						frameReg <= pgl_pkg::FR_IDLE;
					end
				end
			endcase
		end
	end

	// Header and write data shifting
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			hdrShift <= 12'h000;
			wrShift  <= 16'h0000;
		end else if (mdcRise) begin
			if (frameReg == pgl_pkg::FR_HDR) begin
				hdrShift <= hdrFull[11:0];
			end
			if (frameReg == pgl_pkg::FR_DATA) begin
				wrShift <= wrData;
			end
		end
	end

	// Decode header at its last bit; bad start bit or other address ignored
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			isRead  <= 1'b0;
			isWrite <= 1'b0;
			regAddr <= 5'h00;
		end else if (hdrDone) begin
			isRead  <= hdrFull[12] && hdrFull[11:10] == `PGL_OP_READ && hdrFull[9:5] == PHY_ADDR;
			isWrite <= hdrFull[12] && hdrFull[11:10] == `PGL_OP_WRITE && hdrFull[9:5] == PHY_ADDR;
			regAddr <= hdrFull[4:0];
		end
	end

	// Read snapshot taken at header end; side effects fire on this strobe
	assign rdStrobe = hdrDone && hdrFull[12] && hdrFull[11:10] == `PGL_OP_READ
		&& hdrFull[9:5] == PHY_ADDR;
	assign wrStrobe = mdcRise && frameReg == pgl_pkg::FR_DATA && bitCnt == `PGL_DATA_LAST
		&& isWrite;

	// Pin driver: zero in second turnaround bit, then data MSB first
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			mdioO   <= 1'b1;
			mdioOe  <= 1'b0;
			rdShift <= 16'h0000;
		end else if (rdStrobe) begin
			rdShift <= rdValue;
		end else if (mdcRise && isRead) begin
			if (frameReg == pgl_pkg::FR_TA && bitCnt == 4'h0) begin
				mdioOe <= 1'b1;
				mdioO  <= 1'b0;
			end else if (frameReg == pgl_pkg::FR_DATA && bitCnt == `PGL_DATA_LAST) begin
				mdioOe <= 1'b0;
				mdioO  <= 1'b1;
			end else if (frameReg != pgl_pkg::FR_IDLE && frameReg != pgl_pkg::FR_HDR) begin
				mdioO   <= rdShift[15];
				rdShift <= {rdShift[14:0], 1'b0};
			end
		end
	end

	// ****************************************
	// Page selection and indirect access
	// ****************************************
	pgl_pkg::pgl_word_t pageReg;
	pgl_pkg::pgl_word_t mmdCtrlReg;
	pgl_pkg::pgl_word_t mmdAddrReg;
	logic               gpSel;
	logic               mmdData;
	logic [2:0]         eeeIdx;
	logic               eeeRead;
	logic               eeeWrite;

	// Map an indirect device and address onto a low-power register index
	function automatic logic [2:0] lowPowerIndex(input logic [4:0] dev,
		input logic [15:0] addr);
		logic [2:0] idx;
		idx = `PGL_IDX_NONE;
		if (dev == `PGL_MMD_DEV_PCS && addr == `PGL_MMD_A_STATUS) idx = `PGL_IDX_STATUS;
		if (dev == `PGL_MMD_DEV_PCS && addr == `PGL_MMD_A_CAPS)   idx = `PGL_IDX_CAPS;
		if (dev == `PGL_MMD_DEV_PCS && addr == `PGL_MMD_A_WAKE)   idx = `PGL_IDX_WAKE;
		if (dev == `PGL_MMD_DEV_AN  && addr == `PGL_MMD_A_ADV)    idx = `PGL_IDX_ADV;
		if (dev == `PGL_MMD_DEV_AN  && addr == `PGL_MMD_A_LPADV)  idx = `PGL_IDX_LPADV;
		return idx;
	endfunction

	assign gpSel    = (pageReg == `PGL_PAGE_GP);
	assign mmdData  = (mmdCtrlReg[15:14] != 2'h0);
	assign eeeIdx   = lowPowerIndex(mmdCtrlReg[4:0], mmdAddrReg);
	assign eeeRead  = rdStrobe && !gpSel && hdrFull[4:0] == `PGL_REG_MMD_DATA && mmdData;
	assign eeeWrite = wrStrobe && !gpSel && regAddr == `PGL_REG_MMD_DATA && mmdData;

	// Page register answers on every page so the host can always return
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			pageReg <= `PGL_PAGE_STD;
		end else if (wrStrobe && regAddr == `PGL_REG_PAGE) begin
			pageReg <= wrData;
		end
	end

	// Indirect control, address and post-increment on data access
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			mmdCtrlReg <= 16'h0000;
			mmdAddrReg <= 16'h0000;
		end else if (wrStrobe && !gpSel && regAddr == `PGL_REG_MMD_CTRL) begin
			mmdCtrlReg <= wrData;
		end else if (wrStrobe && !gpSel && regAddr == `PGL_REG_MMD_DATA && !mmdData) begin
			mmdAddrReg <= wrData;
		end else if ((eeeRead || eeeWrite) && mmdCtrlReg[15]) begin
			mmdAddrReg <= mmdAddrReg + 16'h0001;
		end
	end

	// ****************************************
	// General-purpose page registers
	// ****************************************
	logic        sleepDirNReg;
	logic        sleepOutReg;
	logic        thermalSrcNReg;
	logic [11:0] portSrcNReg;
	logic        gpIrqRead;

	assign gpIrqRead = rdStrobe && gpSel && hdrFull[4:0] == `PGL_GP_IRQ;

	// Sleep pin direction and data
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			sleepDirNReg <= 1'b1;
			sleepOutReg  <= 1'b0;
		end else if (wrStrobe && gpSel && regAddr == `PGL_GP_SLEEP) begin
			sleepDirNReg <= wrData[`PGL_SLEEP_DIR_N];
			sleepOutReg  <= wrData[`PGL_SLEEP_OUT];
		end
	end

	assign sleepPinOe = ~sleepDirNReg;
	assign sleepPinO  = sleepOutReg;

	// Thermal source: cleared by global read, a new event beats the clear
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			thermalSrcNReg <= 1'b1;
		end else if (thermalIrqEvent) begin
			thermalSrcNReg <= 1'b0;
		end else if (gpIrqRead) begin
			thermalSrcNReg <= 1'b1;
		end
	end

	// Port sources: only the port's own status read returns a flag to 1
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			portSrcNReg <= 12'hFFF;
		end else begin
			portSrcNReg <= (portSrcNReg | portStatusRead) & ~portIrqEvent;
		end
	end

	// Interrupt line follows any active-low source
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			irqOut <= 1'b0;
		end else begin
			irqOut <= ~(thermalSrcNReg & (&portSrcNReg));
		end
	end

	// ****************************************
	// Low-power registers
	// ****************************************
	logic               txSeenReg;
	logic               rxSeenReg;
	logic               gigAdvReg;
	logic               fastAdvReg;
	logic               lpGigReg;
	logic               lpFastReg;
	logic               statusRead;
	pgl_pkg::pgl_word_t wakeCount;

	assign statusRead = eeeRead && eeeIdx == `PGL_IDX_STATUS;

	// Idle-seen latches clear on status read; arrival in that cycle wins
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			txSeenReg <= 1'b0;
			rxSeenReg <= 1'b0;
		end else begin
			txSeenReg <= txIdleNow | (txSeenReg & ~statusRead);
			rxSeenReg <= rxIdleNow | (rxSeenReg & ~statusRead);
		end
	end

	pgl_wake_cnt uWakeCnt (
		.clk_sys      (clk_sys),
		.rstSync_n    (rstSync_n),
		.softReset    (softReset),
		.faultRefresh (wakeFaultRefresh),
		.faultWakeup  (wakeFaultWakeup),
		.readClear    (eeeRead && eeeIdx == `PGL_IDX_WAKE),
		.count        (wakeCount)
	);

	// Local advertisement, writable through the data window only
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			gigAdvReg  <= 1'b0;
			fastAdvReg <= 1'b0;
		end else if (eeeWrite && eeeIdx == `PGL_IDX_ADV) begin
			gigAdvReg  <= wrData[`PGL_GIG_BIT];
			fastAdvReg <= wrData[`PGL_FAST_BIT];
		end
	end

	assign gigAdvertOut  = gigAdvReg;
	assign fastAdvertOut = fastAdvReg;

	// Partner abilities load once negotiation completes; writes ignored
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			lpGigReg  <= 1'b0;
			lpFastReg <= 1'b0;
		end else if (anComplete) begin
			lpGigReg  <= partnerGigAdvert;
			lpFastReg <= partnerFastAdvert;
		end
	end

	// ****************************************
	// Read data selection
	// ****************************************
	pgl_pkg::pgl_word_t eeeValue;

	// Low-power register contents by index
	always_comb begin
		eeeValue = 16'h0000;
		unique case (eeeIdx)
			`PGL_IDX_STATUS: begin
				eeeValue[`PGL_ST_TX_SEEN] = txSeenReg;
				eeeValue[`PGL_ST_RX_SEEN] = rxSeenReg;
				eeeValue[`PGL_ST_TX_NOW]  = txIdleNow;
				eeeValue[`PGL_ST_RX_NOW]  = rxIdleNow;
				eeeValue[`PGL_ST_LINK]    = rxLinkUp;
			end
			`PGL_IDX_CAPS:  eeeValue = `PGL_CAPS_VALUE;
			`PGL_IDX_WAKE:  eeeValue = wakeCount;
			`PGL_IDX_ADV: begin
				eeeValue[`PGL_GIG_BIT]  = gigAdvReg;
				eeeValue[`PGL_FAST_BIT] = fastAdvReg;
			end
			`PGL_IDX_LPADV: begin
				eeeValue[`PGL_GIG_BIT]  = lpGigReg;
				eeeValue[`PGL_FAST_BIT] = lpFastReg;
			end
			default:        eeeValue = 16'h0000;
		endcase
	end

	// Address decode; the selected page owns every address but the page register
	always_comb begin
		rdValue = 16'h0000;
		if (hdrFull[4:0] == `PGL_REG_PAGE) begin
			rdValue = pageReg;
		end else if (gpSel) begin
			if (hdrFull[4:0] == `PGL_GP_SLEEP) begin
				rdValue[`PGL_SLEEP_DIR_N] = sleepDirNReg;
				rdValue[`PGL_SLEEP_OUT]   = sleepOutReg;
				rdValue[`PGL_SLEEP_IN]    = sleepS;
			end else if (hdrFull[4:0] == `PGL_GP_IRQ) begin
				rdValue[`PGL_IRQ_THERMAL] = thermalSrcNReg;
				rdValue[11:0]             = portSrcNReg;
			end
		end else if (hdrFull[4:0] == `PGL_REG_MMD_CTRL) begin
			rdValue = mmdCtrlReg;
		end else if (hdrFull[4:0] == `PGL_REG_MMD_DATA) begin
			rdValue = mmdData ? eeeValue : mmdAddrReg;
		end
	end

endmodule

/* File: bench/pgl_regs_props.sv */
// Purpose: Port assertions for pgl_regs
// Assumes: Bound to every pgl_regs instance
// Notes:   Register side effects only follow mdc activity or a port status read
`timescale 1ns/1ps
module pgl_regs_props (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        mdc,
	input wire logic        mdioO,
	input wire logic        mdioOe,
	input wire logic        sleepPinO,
	input wire logic        sleepPinOe,
	input wire logic        thermalIrqEvent,
	input wire logic [11:0] portIrqEvent,
	input wire logic [11:0] portStatusRead,
	input wire logic        gigAdvertOut,
	input wire logic        fastAdvertOut,
	input wire logic        irqOut
);
	// ********
	// Properties
	// ********
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Sources must reach the interrupt line quickly
	thermal_irq_a: assert property (thermalIrqEvent |-> ##[1:2] irqOut)
		else $error("thermal source missed");
	port_irq_a: assert property (|portIrqEvent |-> ##[1:2] irqOut)
		else $error("port source missed");
	// Line drops only after a status read or a management frame
	irq_clear_a: assert property ($fell(irqOut) |-> mdc ||
		$past(portStatusRead, 2) != 12'h000 || $past(portStatusRead, 3) != 12'h000)
		else $error("interrupt dropped without read");
	// Pin control moves only on a write commit
	sleep_dir_a: assert property ($changed(sleepPinOe) |-> mdc && !mdioOe)
		else $error("sleep direction moved");
	sleep_out_a: assert property (!$stable(sleepPinO) |-> mdc && !mdioOe)
		else $error("sleep data moved");
	advert_out_a: assert property ($changed({gigAdvertOut, fastAdvertOut}) |-> mdc)
		else $error("advert moved");
	// Turnaround starts with a driven zero, then holds
	turn_zero_a: assert property ($rose(mdioOe) |-> !mdioO && mdc)
		else $error("turnaround not zero");
	drive_hold_a: assert property ($rose(mdioOe) |=> mdioOe [*8])
		else $error("read drive too short");
	cover property (thermalIrqEvent);
	cover property ($rose(mdioOe));
	cover property ($rose(sleepPinOe));
endmodule
bind pgl_regs pgl_regs_props u_props (.clk_sys, .rst_n, .mdc, .mdioO, .mdioOe,
	.sleepPinO, .sleepPinOe, .thermalIrqEvent, .portIrqEvent, .portStatusRead,
	.gigAdvertOut, .fastAdvertOut, .irqOut);

/* File: bench/pgl_mgmt_host.sv */
// Purpose: Management station model sending whole frames
// Assumes: mdio has a pull-up, so a released line reads 1
// Notes:   mdc idles high between frames; period 20 clocks
`timescale 1ns/1ps
`include "pgl_cfg.svh"
module pgl_mgmt_host (
	input  wire logic clk_sys,
	input  wire logic mdioLine,
	output logic      mdc,
	output logic      hostOe,
	output logic      hostD
);
	// ********
	// Frame engine
	// ********
	initial begin
		mdc = 1'b1;
		hostOe = 1'b0;
		hostD = 1'b1;
	end
	// Data held across the rise; sampled just before it
	task automatic bitc(input logic en, input logic b, output logic s);
		@(posedge clk_sys);
		#1;
		mdc = 1'b0;
		hostOe = en;
		hostD = b;
		repeat (10) @(posedge clk_sys);
		s = mdioLine;
		#1;
		mdc = 1'b1;
		repeat (9) @(posedge clk_sys);
		#1;
	endtask
	// Full preamble each frame keeps back-to-back frames legal
	task automatic xfer(input logic rd, input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] q);
		logic [13:0] hdr;
		logic [17:0] tl;
		logic        s;
		hdr = {2'h1, rd ? `PGL_OP_READ : `PGL_OP_WRITE, `PGL_PHY_ADDR, ra};
		tl = {2'h2, wd};
		q = 16'h0000;
		for (int i = 0; i < 32; i++) bitc(1'b1, 1'b1, s);
		for (int i = 13; i >= 0; i--) bitc(1'b1, hdr[i], s);
		for (int i = 17; i >= 0; i--) begin
			bitc(!rd, tl[i], s);
			q = {q[14:0], s};
		end
		hostOe = 1'b0;
	endtask
endmodule

/* File: bench/tb_pgl_regs.sv */
// Purpose: Self-checking bench for pgl_regs
// Assumes: Host model drives frames; checker is bound
// Notes:   Expected words come from models kept here
`timescale 1ns/1ps
module tb_pgl_regs;
	logic        clk_sys, rst_n, softReset, mdc, mdioO, mdioOe, hostOe, hostD, sleepExt;
	logic        sleepPinO, sleepPinOe, thermalIrqEvent, txIdleNow, rxIdleNow, rxLinkUp;
	logic        wakeFaultRefresh, wakeFaultWakeup, anComplete, partnerGigAdvert;
	logic        partnerFastAdvert, gigAdvertOut, fastAdvertOut, irqOut;
	logic [11:0] portIrqEvent, portStatusRead;
	logic [15:0] q, pm, e;
	logic [2:0]  v;
	int          n_errors, total_checks, seed, nw;
	wire         mdioLine, sleepLine;
	// Pull-up on mdio; the pin follows whoever drives it
	assign mdioLine = mdioOe ? mdioO : (hostOe ? hostD : 1'b1);
	assign sleepLine = sleepPinOe ? sleepPinO : sleepExt;
	pgl_regs dut (.clk_sys, .rst_n, .softReset, .mdc, .mdioI(mdioLine), .mdioO, .mdioOe,
		.sleepPinI(sleepLine), .sleepPinO, .sleepPinOe, .thermalIrqEvent, .portIrqEvent,
		.portStatusRead, .txIdleNow, .rxIdleNow, .rxLinkUp, .wakeFaultRefresh,
		.wakeFaultWakeup, .anComplete, .partnerGigAdvert, .partnerFastAdvert,
		.gigAdvertOut, .fastAdvertOut, .irqOut);
	pgl_mgmt_host host (.clk_sys, .mdioLine, .mdc, .hostOe, .hostD);
	// ********
	// Tasks
	// ********
	task automatic tick;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] x);
		total_checks++;
		if (s !== x) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, s, x);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		host.xfer(1'b0, a, d, q);
	endtask
	task automatic rdc(input logic [4:0] a, input logic [15:0] x);
		host.xfer(1'b1, a, 16'h0000, q);
		chk(q, x);
	endtask
	// Point the data window at one indirect register
	task automatic mmd(input logic [4:0] dv, input logic [15:0] ad);
		wr(5'h0D, {11'h000, dv});
		wr(5'h0E, ad);
		wr(5'h0D, 16'h4000 | {11'h000, dv});
	endtask
	task automatic results;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ********
	// Clock, watchdog, sequence
	// ********
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (100000) @(posedge clk_sys);
		n_errors++;
		results;
	end
	initial begin
		seed = 32'hA9AF_4D70;
		{rst_n, softReset, thermalIrqEvent, txIdleNow, rxIdleNow, rxLinkUp} = '0;
		{wakeFaultRefresh, wakeFaultWakeup, anComplete, partnerGigAdvert} = '0;
		{partnerFastAdvert, portIrqEvent, portStatusRead} = '0;
		sleepExt = 1'b1;
		n_errors = 0;
		total_checks = 0;
		repeat (5) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		repeat (8) tick;
		wr(5'h0D, 16'h0003);
		wr(5'h1F, 16'h0010);
		rdc(5'h0D, 16'h0000);
		rdc(5'h0E, 16'h2800);
		wr(5'h0E, 16'h1000);
		sleepExt = 1'b0;
		rdc(5'h0E, 16'h1800);
		chk({14'h0000, sleepPinOe, sleepPinO}, 16'h0003);
		wr(5'h0E, 16'h2000);
		rdc(5'h0E, 16'h2000);
		chk({14'h0000, sleepPinOe, sleepPinO}, 16'h0000);
		// Random port sources plus the thermal one
		pm = (16'($random(seed)) & 16'h0FFF) | 16'h0001;
		thermalIrqEvent = 1'b1;
		portIrqEvent = pm[11:0];
		tick;
		{thermalIrqEvent, portIrqEvent} = '0;
		repeat (2) tick;
		chk({15'h0000, irqOut}, 16'h0001);
		rdc(5'h1D, 16'h0FFF & ~pm);
		rdc(5'h1D, 16'h1FFF & ~pm);
		chk({15'h0000, irqOut}, 16'h0001);
		portStatusRead = pm[11:0];
		tick;
		portStatusRead = '0;
		rdc(5'h1D, 16'h1FFF);
		chk({15'h0000, irqOut}, 16'h0000);
		wr(5'h1F, 16'h0000);
		rdc(5'h0D, 16'h0003);
		rdc(5'h01, 16'h0000);
		mmd(5'h03, 16'h0014);
		wr(5'h0E, 16'h0000);
		rdc(5'h0E, 16'h0006);
		// Idle and link levels from the random stream
		v = 3'($random(seed));
		{txIdleNow, rxIdleNow, rxLinkUp} = v;
		mmd(5'h03, 16'h0001);
		e = {4'h0, v[2], v[1], v[2], v[1], 5'h00, v[0], 2'h0};
		rdc(5'h0E, e);
		{txIdleNow, rxIdleNow} = 2'h0;
		e[9:8] = 2'h0;
		rdc(5'h0E, e);
		e[11:10] = 2'h0;
		rdc(5'h0E, e);
		mmd(5'h03, 16'h0016);
		nw = 0;
		for (int i = 0; i < 7; i++) begin
			{wakeFaultRefresh, wakeFaultWakeup} = (i == 6) ? 2'h3 : 2'($random(seed));
			nw += wakeFaultRefresh + wakeFaultWakeup;
			tick;
		end
		{wakeFaultRefresh, wakeFaultWakeup} = 2'h0;
		rdc(5'h0E, 16'(nw));
		rdc(5'h0E, 16'h0000);
		wakeFaultWakeup = 1'b1;
		tick;
		wakeFaultWakeup = 1'b0;
		softReset = 1'b1;
		tick;
		softReset = 1'b0;
		rdc(5'h0E, 16'h0000);
		mmd(5'h07, 16'h003C);
		wr(5'h0E, 16'h0006);
		rdc(5'h0E, 16'h0006);
		chk({14'h0000, gigAdvertOut, fastAdvertOut}, 16'h0003);
		wr(5'h0E, 16'h0002);
		chk({14'h0000, gigAdvertOut, fastAdvertOut}, 16'h0001);
		{anComplete, partnerGigAdvert} = 2'h3;
		wr(5'h0D, 16'h8007);
		rdc(5'h0E, 16'h0002);
		wr(5'h0D, 16'h4007);
		wr(5'h0E, 16'hFFFF);
		rdc(5'h0E, 16'h0004);
		results;
	end
endmodule
